// >>> src/mtc_regs.svh
// Constants for the measurement trigger control block.
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH
`define MTC_NUM_CHAN 3
`define MTC_CHAN_EN_RST 3'h7
`define MTC_REF_INTERNAL 2'h0
`define MTC_REF_EXTERNAL 2'h1
`define MTC_REF_HOST 2'h2
`define MTC_UNIT_WATT 1'h0
`define MTC_UNIT_DBM 1'h1
`define MTC_ORDER_LITTLE 1'h0
`define MTC_ORDER_BIG 1'h1
`define MTC_SRF_DEC 2'h0
`define MTC_SRF_HEX 2'h1
`define MTC_SRF_OCT 2'h2
`define MTC_SRF_BIN 2'h3
`define MTC_DATA_TEXT 2'h0
`define MTC_DATA_BIN32 2'h1
`define MTC_DATA_BIN64 2'h2
`define MTC_SRC_HOLD 3'h0
`define MTC_SRC_IMMEDIATE 3'h1
`define MTC_SRC_INTERNAL 3'h2
`define MTC_SRC_EXT1 3'h3
`define MTC_SRC_EXT2 3'h4
`define MTC_SRC_BUS 3'h5
`define MTC_SLOPE_RISE 1'h0
`define MTC_SLOPE_FALL 1'h1
`define MTC_BYTES_PER_WORD 4'h8
`define MTC_LAST_BYTE 3'h7
`define MTC_DELAY_W 16
`endif

// >>> src/mtc_pkg.sv
// Types for the measurement trigger control block.
package mtc_pkg;
  typedef enum logic [2:0] {
    MTC_IDLE = 3'b001,
    MTC_WAIT = 3'b010,
    MTC_MEAS = 3'b100
  } mtc_state_t;
endpackage

// >>> src/mtc_byte_serializer.sv
// Serialises one 64-bit result into eight bytes in the selected byte order.
`timescale 1ns/1ps
`include "mtc_regs.svh"
module mtc_byte_serializer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic big_endian_order,
  input wire logic word_valid,
  input wire logic [63:0] word_data,
  output logic word_ready,
  output logic byte_valid,
  input wire logic byte_ready,
  output logic [7:0] byte_data,
  output logic byte_last
);
  logic [63:0] word_r;
  logic [2:0] idx_r;
  logic busy_r;
  logic order_r;
  logic [2:0] lane;
  logic load;
  logic step;
  assign word_ready = ~busy_r;
  assign byte_valid = busy_r;
  assign load = clk_en & word_valid & ~busy_r;
  assign step = clk_en & busy_r & byte_ready;
  // Order is latched with the word so a setting change mid-word cannot mix orders.
  assign lane = order_r ? (`MTC_LAST_BYTE - idx_r) : idx_r;
  assign byte_data = word_r[lane*8 +: 8];
  assign byte_last = busy_r & (idx_r == `MTC_LAST_BYTE);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_r <= 64'h0;
      idx_r <= 3'h0;
      busy_r <= 1'b0;
      order_r <= `MTC_ORDER_LITTLE;
    end else if (load) begin
      word_r <= word_data;
      idx_r <= 3'h0;
      busy_r <= 1'b1;
      order_r <= big_endian_order;
    end else if (step) begin
      idx_r <= idx_r + 3'h1;
      busy_r <= (idx_r != `MTC_LAST_BYTE);
    end
  end
endmodule // mtc_byte_serializer

// >>> src/mtc_top.sv
// Measurement sequencer, trigger selection and result format control.
`timescale 1ns/1ps
`include "mtc_regs.svh"
// Functional notes
// - Each channel has an enable; all channels enabled after reset.
// - Enabled channel without antenna raises a static error blinking the LED.
// - Reference selects internal oscillator or external; internal after reset.
// - External and host reference settings both use the host connector signal.
// - Power reported in log milliwatt units or watts; watts after reset.
// - Byte order applies to 64-bit binary results; little endian after reset.
// - Normal order sends least significant byte first, most significant eighth.
// - Big_endian_order order sends most significant byte first, least significant eighth.
// - Status byte format decimal, hex, base8_status_format or binary; decimal after reset.
// - Block data as text or binary 32 or 64 bit; text after reset.
// - Sequencer is idle after power-up, no measurement.
// - Initiate while idle moves to waiting for trigger.
// - Selected trigger event moves wait to measuring until measurement completes.
// - Completion restarts or returns idle depending on single or continuous.
// - Continuous initiation begins a new cycle after each cycle ends.
// - Single initiation runs one measurement then returns to idle.
// - Level trigger on rise or fall starts measuring after configured delay.
// - Hold and bus sources trigger only by command; bus also takes common trigger.
// - Immediate source starts measuring at once without a trigger condition.
// - Internal source derives triggers from the measured RF signal.
// - External sources take digital inputs from cable pair and coaxial connector.
// - Forced trigger command ends the wait for every source except immediate.
module mtc_top #(
  parameter int NUM_CHAN = `MTC_NUM_CHAN,
  parameter int DELAY_W = `MTC_DELAY_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [NUM_CHAN-1:0] chan_enable_set,
  input wire logic chan_enable_we,
  input wire logic [NUM_CHAN-1:0] antenna_present,
  output logic [NUM_CHAN-1:0] chan_enable,
  output logic static_error,
  input wire logic blink_tick,
  output logic status_led_blink,
  input wire logic [1:0] ref_source_set,
  input wire logic ref_source_we,
  input wire logic ref_host_clk_present,
  output logic ref_use_host_connector,
  input wire logic unit_set,
  input wire logic unit_we,
  output logic log_milliwatt_unit,
  input wire logic order_set,
  input wire logic order_we,
  output logic big_endian_order,
  input wire logic [1:0] status_format_set,
  input wire logic status_format_we,
  output logic base16_status_format,
  output logic base8_status_format,
  output logic base2_status_format,
  input wire logic [1:0] data_format_set,
  input wire logic data_format_we,
  output logic [1:0] data_format,
  input wire logic [2:0] trig_source_set,
  input wire logic trig_source_we,
  input wire logic trig_slope_set,
  input wire logic trig_slope_we,
  input wire logic [DELAY_W-1:0] trig_delay_set,
  input wire logic trig_delay_we,
  input wire logic init_single,
  input wire logic init_cont_set,
  input wire logic init_cont_we,
  input wire logic trig_force_cmd,
  input wire logic common_trig_cmd,
  input wire logic rf_above_level,
  input wire logic ext1_trig_pin,
  input wire logic ext2_trig_pin,
  input wire logic meas_done,
  output logic meas_start,
  output logic state_idle,
  output logic state_waiting,
  output logic state_measuring,
  input wire logic result_valid,
  input wire logic [63:0] result_data,
  output logic result_ready,
  output logic byte_valid,
  input wire logic byte_ready,
  output logic [7:0] byte_data,
  output logic byte_last
);
  logic [NUM_CHAN-1:0] chan_en_r;
  logic [1:0] ref_src_r;
  logic unit_r;
  logic order_r;
  logic [1:0] srf_r;
  logic [1:0] data_fmt_r;
  logic [2:0] src_r;
  logic slope_r;
  logic [DELAY_W-1:0] delay_r;
  logic cont_r;
  mtc_pkg::mtc_state_t state_r;
  mtc_pkg::mtc_state_t state_nxt;
  logic [2:0] ext1_sync_r;
  logic [2:0] ext2_sync_r;
  logic [2:0] rf_sync_r;
  logic armed_r;
  logic [DELAY_W-1:0] delay_cnt_r;
  logic start_r;
  logic blink_r;
  logic rf_edge;
  logic ext1_edge;
  logic ext2_edge;
  logic src_event;
  logic forced;
  logic fire;
  logic go_meas;
  logic [NUM_CHAN-1:0] missing;
  logic data_fmt_ok;
  logic src_ok;

  function automatic logic edge_of(input logic [2:0] sync, input logic fall);
    edge_of = fall ? (sync[2] & ~sync[1]) : (~sync[2] & sync[1]);
  endfunction

  // Data format and trigger source codes outside the defined sets are dropped so a bad write cannot leave an undecodable setting.
  assign data_fmt_ok = (data_format_set <= `MTC_DATA_BIN64);
  assign src_ok = (trig_source_set <= `MTC_SRC_BUS);

  // Settings registers, one per setting, each loaded by its own strobe.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_en_r <= NUM_CHAN'(`MTC_CHAN_EN_RST);
    end else if (clk_en && chan_enable_we) begin
      chan_en_r <= chan_enable_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_src_r <= `MTC_REF_INTERNAL;
    end else if (clk_en && ref_source_we) begin
      ref_src_r <= ref_source_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      unit_r <= `MTC_UNIT_WATT;
    end else if (clk_en && unit_we) begin
      unit_r <= unit_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      order_r <= `MTC_ORDER_LITTLE;
    end else if (clk_en && order_we) begin
      order_r <= order_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      srf_r <= `MTC_SRF_DEC;
    end else if (clk_en && status_format_we) begin
      srf_r <= status_format_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_fmt_r <= `MTC_DATA_TEXT;
    end else if (clk_en && data_format_we && data_fmt_ok) begin
      data_fmt_r <= data_format_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_r <= `MTC_SRC_IMMEDIATE;
    end else if (clk_en && trig_source_we && src_ok) begin
      src_r <= trig_source_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slope_r <= `MTC_SLOPE_RISE;
    end else if (clk_en && trig_slope_we) begin
      slope_r <= trig_slope_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      delay_r <= '0;
    end else if (clk_en && trig_delay_we) begin
      delay_r <= trig_delay_set;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cont_r <= 1'h0;
    end else if (clk_en && init_cont_we) begin
      cont_r <= init_cont_set;
    end
  end

  assign chan_enable = chan_en_r;
  assign missing = chan_en_r & ~antenna_present;
  assign static_error = |missing;
  assign ref_use_host_connector = (ref_src_r == `MTC_REF_EXTERNAL) || (ref_src_r == `MTC_REF_HOST);
  assign log_milliwatt_unit = unit_r;
  assign big_endian_order = order_r;
  assign base16_status_format = (srf_r == `MTC_SRF_HEX);
  assign base8_status_format = (srf_r == `MTC_SRF_OCT);
  assign base2_status_format = (srf_r == `MTC_SRF_BIN);
  assign data_format = data_fmt_r;

  // Pin inputs pass three flops; only the later two stages feed edge detection.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext1_sync_r <= 3'h0;
    end else if (clk_en) begin
      ext1_sync_r <= {ext1_sync_r[1:0], ext1_trig_pin};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext2_sync_r <= 3'h0;
    end else if (clk_en) begin
      ext2_sync_r <= {ext2_sync_r[1:0], ext2_trig_pin};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rf_sync_r <= 3'h0;
    end else if (clk_en) begin
      rf_sync_r <= {rf_sync_r[1:0], rf_above_level};
    end
  end

  // The blink phase restarts from dark each time the error clears.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_r <= 1'h0;
    end else if (clk_en) begin
      if (!static_error) begin
        blink_r <= 1'h0;
      end else if (blink_tick) begin
        blink_r <= ~blink_r;
      end
    end
  end
  assign status_led_blink = blink_r;

  assign rf_edge = edge_of(rf_sync_r, slope_r);
  assign ext1_edge = edge_of(ext1_sync_r, slope_r);
  assign ext2_edge = edge_of(ext2_sync_r, slope_r);

  // Hold and bus have no hardware event; only commands reach them.
  always_comb begin
    case (src_r)
      `MTC_SRC_INTERNAL: src_event = rf_edge;
      `MTC_SRC_EXT1: src_event = ext1_edge;
      `MTC_SRC_EXT2: src_event = ext2_edge;
      `MTC_SRC_BUS: src_event = common_trig_cmd;
      default: src_event = 1'b0;
    endcase
  end
  assign forced = trig_force_cmd && (src_r != `MTC_SRC_IMMEDIATE);
  // A forced trigger also cuts a running delay short; source events are ignored while armed.
  assign fire = (state_r == mtc_pkg::MTC_WAIT) && ((!armed_r && src_event) || forced);
  // The delay applies to the level, cable and coaxial sources; commands start at once.
  assign go_meas = (state_r == mtc_pkg::MTC_WAIT) &&
                   ((src_r == `MTC_SRC_IMMEDIATE) ||
                    (fire && (forced || delay_r == '0 || src_r == `MTC_SRC_BUS)) ||
                    (armed_r && delay_cnt_r == '0));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mtc_pkg::MTC_IDLE: begin
        if (init_single || cont_r) begin
          state_nxt = mtc_pkg::MTC_WAIT;
        end
      end
      mtc_pkg::MTC_WAIT: begin
        if (go_meas) begin
          state_nxt = mtc_pkg::MTC_MEAS;
        end
      end
      mtc_pkg::MTC_MEAS: begin
        if (meas_done) begin
          state_nxt = cont_r ? mtc_pkg::MTC_WAIT : mtc_pkg::MTC_IDLE;
        end
      end
      default: state_nxt = mtc_pkg::MTC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= mtc_pkg::MTC_IDLE;
      start_r <= 1'h0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      start_r <= go_meas;
    end
  end

  // An armed delay ignores further source events so one edge yields one measurement.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_r <= 1'h0;
      delay_cnt_r <= '0;
    end else if (clk_en) begin
      if (go_meas || state_r != mtc_pkg::MTC_WAIT) begin
        armed_r <= 1'h0;
      end else if (fire && !forced && delay_r != '0 && src_r != `MTC_SRC_BUS) begin
        armed_r <= 1'h1;
        delay_cnt_r <= delay_r - DELAY_W'(1);
      end else if (armed_r) begin
        delay_cnt_r <= delay_cnt_r - DELAY_W'(1);
      end
    end
  end

  assign meas_start = start_r;
  assign state_idle = (state_r == mtc_pkg::MTC_IDLE);
  assign state_waiting = (state_r == mtc_pkg::MTC_WAIT);
  assign state_measuring = (state_r == mtc_pkg::MTC_MEAS);

  mtc_byte_serializer u_ser (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .big_endian_order(order_r),
    .word_valid(result_valid && data_fmt_r == `MTC_DATA_BIN64),
    .word_data(result_data),
    .word_ready(result_ready),
    .byte_valid(byte_valid),
    .byte_ready(byte_ready),
    .byte_data(byte_data),
    .byte_last(byte_last)
  );
endmodule // mtc_top

// >>> test/mtc_top_assertions.sv
// Port-level checker for the measurement trigger control block.
`timescale 1ns/1ps
module mtc_top_checker #(
  parameter int NUM_CHAN = 3
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [NUM_CHAN-1:0] chan_enable,
  input wire logic [NUM_CHAN-1:0] antenna_present,
  input wire logic static_error,
  input wire logic status_led_blink,
  input wire logic blink_tick,
  input wire logic init_single,
  input wire logic trig_force_cmd,
  input wire logic meas_done,
  input wire logic meas_start,
  input wire logic state_idle,
  input wire logic state_waiting,
  input wire logic state_measuring,
  input wire logic byte_valid,
  input wire logic byte_ready,
  input wire logic [7:0] byte_data,
  input wire logic byte_last
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Counts accepted bytes; eight of them wrap it back to zero at a word boundary.
  logic [2:0] hs_cnt_r;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) hs_cnt_r <= 3'h0;
    else if (clk_en && byte_valid && byte_ready) hs_cnt_r <= hs_cnt_r + 3'h1;
  end
  sequence s_enter_meas;
    $rose(state_measuring);
  endsequence
  sequence s_start_pulse;
    meas_start ##1 !meas_start;
  endsequence
  a_state_onehot: assert property ($onehot({state_idle, state_waiting, state_measuring}))
    else $error("state outputs not one-hot");
  a_init_wait: assert property (clk_en && state_idle && init_single |=> state_waiting)
    else $error("initiate did not reach waiting");
  a_force_meas: assert property (clk_en && state_waiting && trig_force_cmd |=> state_measuring)
    else $error("forced trigger did not start measuring");
  a_meas_start: assert property (s_enter_meas |-> s_start_pulse)
    else $error("start pulse missing after entering measuring");
  a_done_leave: assert property (clk_en && state_measuring && meas_done |=> !state_measuring)
    else $error("measuring kept after completion");
  a_idle_nomeas: assert property (state_idle |=> !state_measuring)
    else $error("measuring entered straight from idle");
  a_err_level: assert property (static_error == |(chan_enable & ~antenna_present))
    else $error("static error level wrong");
  a_led_quiet: assert property (!static_error |=> !status_led_blink)
    else $error("led blinks without static error");
  a_led_toggle: assert property (clk_en && static_error && blink_tick |=>
    status_led_blink != $past(status_led_blink))
    else $error("led did not toggle on blink tick");
  a_byte_hold: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
    else $error("byte changed while stalled");
  a_last_eighth: assert property (byte_valid |-> byte_last == (hs_cnt_r == 3'h7))
    else $error("last flag not on eighth byte");
endmodule // mtc_top_checker
bind mtc_top mtc_top_checker #(.NUM_CHAN(NUM_CHAN)) u_chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .chan_enable(chan_enable),
  .antenna_present(antenna_present),
  .static_error(static_error),
  .status_led_blink(status_led_blink),
  .blink_tick(blink_tick),
  .init_single(init_single),
  .trig_force_cmd(trig_force_cmd),
  .meas_done(meas_done),
  .meas_start(meas_start),
  .state_idle(state_idle),
  .state_waiting(state_waiting),
  .state_measuring(state_measuring),
  .byte_valid(byte_valid),
  .byte_ready(byte_ready),
  .byte_data(byte_data),
  .byte_last(byte_last)
);

// >>> test/mtc_host_model.sv
// Result reader standing in for the remote control computer.
`timescale 1ns/1ps
module mtc_host_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic got,
  output logic [7:0] got_data
);
  logic [1:0] stall_r;
  // Stalls one cycle in four so that held bytes are exercised.
  assign byte_ready = stall_r != 2'h3;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_r <= 2'h0;
      got <= 1'h0;
      got_data <= 8'h00;
    end else begin
      stall_r <= stall_r + 2'h1;
      got <= byte_valid && byte_ready;
      got_data <= byte_data;
    end
  end
endmodule // mtc_host_model

// >>> test/tb.sv
// Self-checking bench for the measurement trigger control block.
`timescale 1ns/1ps
`include "mtc_regs.svh"
module tb;
  logic core_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, chan_enable_we = 1'h0, blink_tick = 1'h0;
  logic ref_source_we = 1'h0, ref_host_clk_present = 1'h0, unit_set = 1'h0, unit_we = 1'h0, order_set = 1'h0;
  logic order_we = 1'h0, status_format_we = 1'h0, data_format_we = 1'h0, trig_source_we = 1'h0;
  logic trig_slope_set = 1'h0, trig_slope_we = 1'h0, trig_delay_we = 1'h0, init_single = 1'h0;
  logic init_cont_set = 1'h0, init_cont_we = 1'h0, trig_force_cmd = 1'h0, common_trig_cmd = 1'h0;
  logic rf_above_level = 1'h0, ext1_trig_pin = 1'h0, ext2_trig_pin = 1'h0, meas_done = 1'h0, result_valid = 1'h0;
  logic [2:0] chan_enable_set = 3'h7, antenna_present = 3'h7, trig_source_set = 3'h0, chan_enable;
  logic [1:0] ref_source_set = 2'h0, status_format_set = 2'h0, data_format_set = 2'h0, data_format;
  logic [15:0] trig_delay_set = 16'h0000;
  logic [63:0] result_data = 64'h0, w;
  logic [7:0] byte_data, got_data;
  logic static_error, status_led_blink, ref_use_host_connector, log_milliwatt_unit, big_endian_order;
  logic base16_status_format, base8_status_format, base2_status_format, meas_start, state_idle;
  logic state_waiting, state_measuring, result_ready, byte_valid, byte_ready, byte_last, got;
  logic [7:0] exp_q[$];
  logic [31:0] lf = 32'h000131a8;
  int n_mismatch = 0, compares = 0, n;
  logic [2:0] srcs[6] = '{`MTC_SRC_HOLD, `MTC_SRC_BUS, `MTC_SRC_INTERNAL, `MTC_SRC_EXT1, `MTC_SRC_EXT2,
    `MTC_SRC_IMMEDIATE};
  mtc_top uut (.*);
  mtc_host_model u_host (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wt(input int sel);
    for (int i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if ({state_idle, state_measuring, state_waiting} === 3'h1 << sel) return;
    end
    chk("state wait", 1'h0, 1'h1);
    results();
  endtask
  task automatic done_pulse;
    @(posedge core_clk);
    meas_done <= 1'h1;
    @(posedge core_clk);
    meas_done <= 1'h0;
  endtask
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) blink_tick <= ~blink_tick;
  always @(posedge core_clk) begin
    if (got === 1'h1 && exp_q.size() > 0) chk("byte", got_data, exp_q.pop_front());
    else if (got === 1'h1) chk("byte count", 1'h1, 1'h0);
  end
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(negedge core_clk);
    chk("chan_enable", chan_enable, `MTC_CHAN_EN_RST);
    chk("ref", ref_use_host_connector, 1'h0);
    chk("unit order", {log_milliwatt_unit, big_endian_order}, 2'h0);
    chk("srf", {base16_status_format, base8_status_format, base2_status_format}, 3'h0);
    chk("data", data_format, `MTC_DATA_TEXT);
    chk("idle", state_idle, 1'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      @(posedge core_clk);
      {ref_source_set, status_format_set, data_format_set} <= {2'(i % 3), 2'(i), 2'(i)};
      {unit_set, order_set} <= {2{i[0]}};
      {chan_enable_set, antenna_present} <= lf[5:0];
      {chan_enable_we, ref_source_we, unit_we, order_we, status_format_we, data_format_we} <= 6'h3f;
      @(posedge core_clk);
      {chan_enable_we, ref_source_we, unit_we, order_we, status_format_we, data_format_we} <= 6'h00;
      @(negedge core_clk);
      chk("ref", ref_use_host_connector, i % 3 != 0);
      chk("srf", {base16_status_format, base8_status_format, base2_status_format}, {i == 1, i == 2, i == 3});
      chk("data", data_format, i == 3 ? `MTC_DATA_BIN64 : 2'(i));
      chk("unit order", {log_milliwatt_unit, big_endian_order}, {2{i[0]}});
      chk("chan", chan_enable, lf[5:3]);
      chk("error", static_error, |(lf[5:3] & ~lf[2:0]));
    end
    $display("test settings done");
    foreach (srcs[k]) begin
      @(posedge core_clk);
      {trig_source_set, trig_source_we} <= {srcs[k], 1'h1};
      @(posedge core_clk);
      {trig_source_we, init_single} <= 2'h1;
      @(posedge core_clk);
      init_single <= 1'h0;
      if (k < 5) begin
        wt(0);
        @(posedge core_clk);
        {ext2_trig_pin, ext1_trig_pin, rf_above_level, common_trig_cmd, trig_force_cmd} <= 5'h1 << k;
        @(posedge core_clk);
        {common_trig_cmd, trig_force_cmd} <= 2'h0;
      end
      wt(1);
      done_pulse();
      {ext2_trig_pin, ext1_trig_pin, rf_above_level} <= 3'h0;
      @(negedge core_clk);
      chk("single idle", state_idle, 1'h1);
    end
    $display("test sources done");
    @(posedge core_clk);
    {init_cont_set, init_cont_we} <= 2'h3;
    @(posedge core_clk);
    init_cont_we <= 1'h0;
    wt(1);
    done_pulse();
    @(negedge core_clk);
    chk("cont rerun", state_idle, 1'h0);
    wt(1);
    @(posedge core_clk);
    {init_cont_set, init_cont_we} <= 2'h1;
    @(posedge core_clk);
    init_cont_we <= 1'h0;
    done_pulse();
    wt(2);
    $display("test continuous done");
    @(posedge core_clk);
    {trig_source_set, trig_source_we, trig_delay_set, trig_delay_we} <= {`MTC_SRC_EXT1, 1'h1, 16'h0005, 1'h1};
    trig_slope_we <= 1'h1;
    @(posedge core_clk);
    {trig_source_we, trig_delay_we, trig_slope_we, init_single} <= 4'h1;
    @(posedge core_clk);
    init_single <= 1'h0;
    wt(0);
    @(posedge core_clk);
    ext1_trig_pin <= 1'h1;
    n = 0;
    while (state_measuring !== 1'h1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    chk("delay", n > 5 && n < 50, 1'h1);
    done_pulse();
    ext1_trig_pin <= 1'h0;
    wt(2);
    $display("test delay done");
    @(posedge core_clk);
    {clk_en, init_single} <= 2'h1;
    @(posedge core_clk);
    init_single <= 1'h0;
    @(negedge core_clk);
    chk("freeze", state_idle, 1'h1);
    clk_en <= 1'h1;
    $display("test clock enable done");
    for (int o = 0; o < 2; o++) begin
      lf = lfsr(lf);
      w = {lf, lfsr(lf)};
      @(posedge core_clk);
      {order_set, order_we} <= {o[0], 1'h1};
      @(posedge core_clk);
      order_we <= 1'h0;
      for (int b = 0; b < 8; b++) exp_q.push_back(o ? w[63 - 8 * b -: 8] : w[8 * b +: 8]);
      result_data <= w;
      result_valid <= 1'h1;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (result_ready !== 1'h1 && n < 50);
      result_valid <= 1'h0;
      chk("load", n < 50, 1'h1);
      n = 0;
      while (exp_q.size() > 0 && n < 60) begin
        @(posedge core_clk);
        n++;
      end
      chk("drain", exp_q.size() == 0, 1'h1);
    end
    $display("test serializer done");
    results();
  end
endmodule // tb
